// ---- inc/vmo_pkg.sv ----
// constants, field layout and state type for the monitor overvoltage response
package vmo_pkg;
    // command codes seen on the management link
    localparam logic [7:0] VMO_CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] VMO_CMD_READING = 8'hF7;
    localparam logic [7:0] VMO_CMD_RESPONSE = 8'hF8;

    // response byte reset value and field positions
    localparam logic [7:0] VMO_RESPONSE_RST = 8'hBF;
    localparam int VMO_ACT_HI = 7;
    localparam int VMO_ACT_LO = 6;
    localparam int VMO_RETRY_HI = 5;
    localparam int VMO_RETRY_LO = 3;
    localparam int VMO_DELAY_HI = 2;
    localparam int VMO_DELAY_LO = 0;

    // action codes, bits 7:6
    localparam logic [1:0] VMO_ACT_IGNORE = 2'h0;
    localparam logic [1:0] VMO_ACT_UNUSED = 2'h1;
    localparam logic [1:0] VMO_ACT_RETRY = 2'h2;
    localparam logic [1:0] VMO_ACT_HOLD = 2'h3;

    // retry codes, bits 5:3
    localparam logic [2:0] VMO_RETRY_NONE = 3'h0;
    localparam logic [2:0] VMO_RETRY_CONT = 3'h7;

    // word widths and synchroniser depth
    localparam int VMO_WORD_W = 16;
    localparam int VMO_CODE_W = 8;
    localparam int VMO_SYNC_DEPTH = 3;

    // retry timebase
    localparam int VMO_CLK_PERIOD_NS = 25;
    localparam int VMO_RETRY_UNIT_MS = 35;
    localparam int VMO_TICK_CYCLES =
        (VMO_RETRY_UNIT_MS * 1000000) / VMO_CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        VMO_RUN,
        VMO_HOLD,
        VMO_LATCHED,
        VMO_WAIT_LOW,
        VMO_STOPPED
    } vmo_state_e;
endpackage

// ---- inc/vmo_xfer_if.sv ----
// command handoff between the link-clock port and the system-clock core
`timescale 1ns/1ps
`default_nettype none
interface vmo_xfer_if;
    import vmo_pkg::*;
    logic req_tgl;
    logic [VMO_CODE_W-1:0] code;
    logic wr;
    logic [VMO_WORD_W-1:0] wdata;
    logic ack_tgl;
    logic [VMO_WORD_W-1:0] rdata;
    logic ok;

    modport link (
        output req_tgl,
        output code,
        output wr,
        output wdata,
        input ack_tgl,
        input rdata,
        input ok
    );
    modport core (
        input req_tgl,
        input code,
        input wr,
        input wdata,
        output ack_tgl,
        output rdata,
        output ok
    );
endinterface
`default_nettype wire

// ---- core/vmo_link_port.sv ----
// link-clock command port: holds one command and waits for the core's answer
`timescale 1ns/1ps
`default_nettype none
module vmo_link_port (
    // link clock and system reset
    input wire logic lnk_clk,
    input wire logic sys_rst,
    // link command side
    input wire logic cmd_valid,
    input wire logic [vmo_pkg::VMO_CODE_W-1:0] cmd_code,
    input wire logic cmd_write,
    input wire logic [vmo_pkg::VMO_WORD_W-1:0] cmd_wdata,
    output logic cmd_busy,
    output logic rsp_valid,
    output logic [vmo_pkg::VMO_WORD_W-1:0] rsp_rdata,
    output logic rsp_ok,
    // core handoff
    vmo_xfer_if.link xf
);
    import vmo_pkg::*;

    typedef struct packed {
        logic [VMO_SYNC_DEPTH-1:0] rst_s;
        logic [VMO_SYNC_DEPTH-1:0] ack_s;
        logic ack_last;
        logic req_tgl;
        logic [VMO_CODE_W-1:0] code;
        logic wr;
        logic [VMO_WORD_W-1:0] wdata;
        logic busy;
        logic rsp_valid;
        logic [VMO_WORD_W-1:0] rdata;
        logic ok;
        logic busy_o;
    } vmo_link_s;

    vmo_link_s q;
    vmo_link_s d;
    logic lrst;
    logic ack_new;

    // reset taken over from the system side, released on the link clock
    assign lrst = q.rst_s[2];
    assign ack_new = (q.ack_s[1] == q.ack_s[2]) && (q.ack_s[2] != q.ack_last);

    always_comb begin
        d = q;
        d.rst_s = {q.rst_s[1:0], sys_rst};
        d.ack_s = {q.ack_s[1:0], xf.ack_tgl};
        d.rsp_valid = 1'b0;
        if (lrst) begin
            d.ack_last = q.ack_s[2];
            d.req_tgl = 1'b0;
            d.busy = 1'b0;
            d.rdata = '0;
            d.ok = 1'b0;
        end else if (q.busy) begin
            // core answers are bundled data, stable once the toggle lands
            if (ack_new) begin
                d.ack_last = q.ack_s[2];
                d.busy = 1'b0;
                d.rsp_valid = 1'b1;
                d.rdata = xf.rdata;
                d.ok = xf.ok;
            end
        end else if (cmd_valid) begin
            d.code = cmd_code;
            d.wr = cmd_write;
            d.wdata = cmd_wdata;
            d.req_tgl = ~q.req_tgl;
            d.busy = 1'b1;
        end
        // busy also covers link reset, kept in a flop for the port
        d.busy_o = d.busy | d.rst_s[2];
    end

    always_ff @(posedge lnk_clk) begin
        q <= d;
    end

    assign xf.req_tgl = q.req_tgl;
    assign xf.code = q.code;
    assign xf.wr = q.wr;
    assign xf.wdata = q.wdata;
    assign cmd_busy = q.busy_o;
    assign rsp_valid = q.rsp_valid;
    assign rsp_rdata = q.rdata;
    assign rsp_ok = q.ok;
endmodule // vmo_link_port
`default_nettype wire

// ---- core/vmo_fault_response.sv ----
// monitor overvoltage response: reading, response byte and restart control
`timescale 1ns/1ps
`default_nettype none
module vmo_fault_response #(
    parameter int TICK_CYCLES = vmo_pkg::VMO_TICK_CYCLES
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // link clock and command port
    input wire logic lnk_clk,
    input wire logic cmd_valid,
    input wire logic [vmo_pkg::VMO_CODE_W-1:0] cmd_code,
    input wire logic cmd_write,
    input wire logic [vmo_pkg::VMO_WORD_W-1:0] cmd_wdata,
    output logic cmd_busy,
    output logic rsp_valid,
    output logic [vmo_pkg::VMO_WORD_W-1:0] rsp_rdata,
    output logic rsp_ok,
    // monitor measurement and comparator results
    input wire logic [vmo_pkg::VMO_WORD_W-1:0] aux_monitor_input,
    input wire logic aux_monitor_sample,
    input wire logic ov_above_limit,
    input wire logic ov_below_recover,
    // control and shutdown sources
    input wire logic write_protect,
    input wire logic commanded_off,
    input wire logic bias_lost,
    input wire logic other_fault_off,
    // power stage and status
    output logic output_enable,
    output logic ov_fault_status,
    output logic retry_pending,
    // open-drain alert, only ever pulled low
    output logic fault_alert_line_o,
    output logic fault_alert_line_oe
);
    import vmo_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int CW = 4;

    typedef struct packed {
        logic [VMO_SYNC_DEPTH-1:0] req_s;
        logic req_last;
        logic ack_tgl;
        logic [VMO_WORD_W-1:0] rdata;
        logic ok;
        logic [7:0] resp;
        logic [VMO_WORD_W-1:0] meas;
        logic fault;
        logic alert_oe;
        logic out_en;
        logic pending;
        vmo_state_e state;
        logic [TW-1:0] tick_cnt;
        logic [CW-1:0] retry_cnt;
    } vmo_core_s;

    vmo_core_s q;
    vmo_core_s d;

    vmo_xfer_if xf ();

    vmo_link_port u_link (
        .lnk_clk(lnk_clk),
        .sys_rst(sys_rst),
        .cmd_valid(cmd_valid),
        .cmd_code(cmd_code),
        .cmd_write(cmd_write),
        .cmd_wdata(cmd_wdata),
        .cmd_busy(cmd_busy),
        .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata),
        .rsp_ok(rsp_ok),
        .xf(xf)
    );

    logic req_new;
    logic clear_req;
    logic tick;
    logic ov_event;
    logic stop_req;
    logic [1:0] act;
    logic [2:0] retry_code;
    logic [CW-1:0] spacing;

    assign act = q.resp[VMO_ACT_HI:VMO_ACT_LO];
    assign retry_code = q.resp[VMO_RETRY_HI:VMO_RETRY_LO];
    assign spacing = {1'b0, q.resp[VMO_DELAY_HI:VMO_DELAY_LO]} + 4'h1;
    assign stop_req = commanded_off | bias_lost | other_fault_off;
    // only the synchronised copies are compared, never the first stage
    assign req_new = (q.req_s[1] == q.req_s[2]) && (q.req_s[2] != q.req_last);

    // ignore unless an acting code is set
    assign ov_event = ov_above_limit && q.out_en && (q.state == VMO_RUN)
        && (act == VMO_ACT_RETRY || act == VMO_ACT_HOLD);

    always_comb begin
        d = q;
        d.req_s = {q.req_s[1:0], xf.req_tgl};
        clear_req = 1'b0;
        tick = 1'b0;

        if (q.tick_cnt == '0) begin
            d.tick_cnt = TW'(TICK_CYCLES - 1);
            tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt - 1'b1;
        end
        if (tick && q.retry_cnt != '0) begin
            d.retry_cnt = q.retry_cnt - 1'b1;
        end

        if (aux_monitor_sample) begin
            d.meas = aux_monitor_input;
        end

        // command decode; the link holds its fields steady while waiting
        if (req_new) begin
            d.req_last = q.req_s[2];
            d.ack_tgl = ~q.ack_tgl;
            d.ok = 1'b1;
            d.rdata = '0;
            case (xf.code)
                VMO_CMD_READING: begin
                    if (xf.wr) begin
                        d.ok = 1'b0;
                    end else begin
                        d.rdata = q.meas;
                    end
                end
                VMO_CMD_RESPONSE: begin
                    if (!xf.wr) begin
                        d.rdata = {8'h00, q.resp};
                    end else if (write_protect) begin
                        d.ok = 1'b0;
                    end else begin
                        d.resp = xf.wdata[7:0];
                    end
                end
                VMO_CMD_CLEAR_FAULTS: begin
                    clear_req = xf.wr;
                    d.ok = xf.wr;
                end
                default: begin
                    d.ok = 1'b0;
                end
            endcase
        end

        // sticky status and alert, new fault beats clear
        if (ov_event) begin
            d.fault = 1'b1;
        end else if (clear_req) begin
            d.fault = 1'b0;
        end
        d.alert_oe = d.fault;

        case (q.state)
            VMO_RUN: begin
                if (ov_event) begin
                    d.out_en = 1'b0;
                    if (act == VMO_ACT_HOLD) begin
                        d.state = VMO_HOLD;
                    end else if (retry_code == VMO_RETRY_CONT) begin
                        d.state = VMO_WAIT_LOW;
                        d.retry_cnt = spacing;
                        d.tick_cnt = TW'(TICK_CYCLES - 1);
                    end else begin
                        d.state = VMO_LATCHED;
                    end
                end
            end
            VMO_HOLD: begin
                if (ov_below_recover) begin
                    d.state = VMO_RUN;
                    d.out_en = 1'b1;
                end
            end
            VMO_LATCHED: begin
                if (clear_req) begin
                    d.state = VMO_RUN;
                    d.out_en = 1'b1;
                end
            end
            VMO_WAIT_LOW: begin
                if (ov_below_recover && q.retry_cnt == '0) begin
                    d.state = VMO_RUN;
                    d.out_en = 1'b1;
                    d.retry_cnt = spacing;
                    d.tick_cnt = TW'(TICK_CYCLES - 1);
                end
            end
            VMO_STOPPED: begin
                if (!stop_req) begin
                    d.state = VMO_RUN;
                    d.out_en = 1'b1;
                end
            end
            default: begin
                d.state = VMO_RUN;
            end
        endcase

        if (stop_req) begin
            d.state = VMO_STOPPED;
            d.out_en = 1'b0;
        end
        d.pending = (d.state == VMO_WAIT_LOW);

        if (sys_rst) begin
            d.req_last = q.req_s[2];
            d.ack_tgl = 1'b0;
            d.rdata = '0;
            d.ok = 1'b0;
            d.resp = VMO_RESPONSE_RST;
            d.meas = '0;
            d.fault = 1'b0;
            d.alert_oe = 1'b0;
            d.out_en = 1'b1;
            d.pending = 1'b0;
            d.state = VMO_RUN;
            d.tick_cnt = TW'(TICK_CYCLES - 1);
            d.retry_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    assign xf.ack_tgl = q.ack_tgl;
    assign xf.rdata = q.rdata;
    assign xf.ok = q.ok;

    assign output_enable = q.out_en;
    assign ov_fault_status = q.fault;
    assign retry_pending = q.pending;
    // alert drives only low; the pull-up gives the idle high
    assign fault_alert_line_o = 1'b0;
    assign fault_alert_line_oe = q.alert_oe;
endmodule // vmo_fault_response
`default_nettype wire

// ---- bench/vmo_host_model.sv ----
// host model for the link command port; the link clock runs only during reset and per command
`timescale 1ns/1ps
`default_nettype none
module vmo_host_model (
    // link clock and request
    output logic lnk_clk,
    output logic cmd_valid,
    output logic [vmo_pkg::VMO_CODE_W-1:0] cmd_code,
    output logic cmd_write,
    output logic [vmo_pkg::VMO_WORD_W-1:0] cmd_wdata,
    // answer
    input wire logic cmd_busy,
    input wire logic rsp_valid,
    input wire logic [vmo_pkg::VMO_WORD_W-1:0] rsp_rdata,
    input wire logic rsp_ok
);
    import vmo_pkg::*;
    initial begin
        lnk_clk = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_write = 1'b0;
        cmd_wdata = 16'h0000;
    end
    // one 125 ns period, ends just after the rising edge
    task automatic run(input int n);
        repeat (n) begin
            #61.5 lnk_clk = 1'b0;
            #62.5 lnk_clk = 1'b1;
            #1;
        end
    endtask
    task automatic xfer(input logic [7:0] c, input logic w,
            input logic [15:0] d, output logic [15:0] rd, output logic ok);
        int n;
        n = 0;
        while (cmd_busy !== 1'b0 && n < 40) begin
            run(1);
            n++;
        end
        cmd_code <= c;
        cmd_write <= w;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        run(1);
        // released code and data lines must not keep the old value
        cmd_valid <= 1'b0;
        cmd_code <= ~c;
        cmd_wdata <= ~d;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 40) begin
            run(1);
            n++;
        end
        rd = rsp_rdata;
        ok = rsp_ok;
        // a lost answer must not pass as the previous one
        if (rsp_valid !== 1'b1) begin
            rd = 'x;
            ok = 1'bx;
        end
    endtask
endmodule // vmo_host_model
`default_nettype wire

// ---- bench/vmo_fault_response_props.sv ----
// port assertions for the monitor overvoltage response
`timescale 1ns/1ps
`default_nettype none
module vmo_fault_response_props #(
    parameter int TICK_CYCLES = 20
) (
    // clocks and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic lnk_clk,
    // link port
    input wire logic cmd_valid,
    input wire logic cmd_busy,
    input wire logic rsp_valid,
    // fault and stop inputs
    input wire logic ov_above_limit,
    input wire logic ov_below_recover,
    input wire logic commanded_off,
    input wire logic bias_lost,
    input wire logic other_fault_off,
    // outputs
    input wire logic output_enable,
    input wire logic ov_fault_status,
    input wire logic retry_pending,
    input wire logic fault_alert_line_o,
    input wire logic fault_alert_line_oe
);
    int wait_q;
    // cycles spent waiting for a restart
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !retry_pending) begin
            wait_q <= 0;
        end else begin
            wait_q <= wait_q + 1;
        end
    end
    alert_level_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        !fault_alert_line_o)
        else $error("alert line driven high");
    alert_status_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        fault_alert_line_oe == ov_fault_status)
        else $error("alert and status differ");
    reset_state_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(sys_rst) |-> output_enable && !ov_fault_status
        && !retry_pending)
        else $error("bad state after reset");
    trip_cause_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(ov_fault_status) |-> !output_enable
        && $past(ov_above_limit) && $past(output_enable))
        else $error("fault flagged without cause");
    stop_off_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (commanded_off || bias_lost || other_fault_off) |=> !output_enable)
        else $error("output on while stopped");
    restart_recover_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(retry_pending) && $rose(output_enable)
        |-> $past(ov_below_recover))
        else $error("restart while voltage high");
    retry_spacing_a: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(retry_pending) && output_enable
        |-> $past(wait_q) >= TICK_CYCLES - 2)
        else $error("restart spacing too short");
    busy_take_a: assert property (
        @(posedge lnk_clk) disable iff (sys_rst)
        cmd_valid && !cmd_busy |=> cmd_busy)
        else $error("command not taken");
    rsp_pulse_a: assert property (
        @(posedge lnk_clk) disable iff (sys_rst)
        rsp_valid |=> !rsp_valid)
        else $error("answer longer than one cycle");
endmodule // vmo_fault_response_props
bind vmo_fault_response vmo_fault_response_props #(.TICK_CYCLES(TICK_CYCLES))
    u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .lnk_clk(lnk_clk),
    .cmd_valid(cmd_valid), .cmd_busy(cmd_busy), .rsp_valid(rsp_valid),
    .ov_above_limit(ov_above_limit), .ov_below_recover(ov_below_recover),
    .commanded_off(commanded_off), .bias_lost(bias_lost),
    .other_fault_off(other_fault_off), .output_enable(output_enable),
    .ov_fault_status(ov_fault_status), .retry_pending(retry_pending),
    .fault_alert_line_o(fault_alert_line_o),
    .fault_alert_line_oe(fault_alert_line_oe));
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the monitor overvoltage response
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vmo_pkg::*;
    localparam int TICK = 20;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic lnk_clk, cmd_valid, cmd_write, cmd_busy, rsp_valid, rsp_ok;
    logic [VMO_CODE_W-1:0] cmd_code;
    logic [VMO_WORD_W-1:0] cmd_wdata, rsp_rdata;
    logic [VMO_WORD_W-1:0] aux_in = 16'h0000;
    logic aux_smp = 1'b0;
    logic ov_above_limit = 1'b0;
    logic ov_below_recover = 1'b0;
    logic write_protect = 1'b0;
    logic [2:0] stop = 3'h0;
    logic output_enable, ov_fault_status, retry_pending, alert_o, alert_oe;
    logic [15:0] rd;
    logic ok;
    int failures = 0;
    int total_checks = 0;
    vmo_fault_response #(.TICK_CYCLES(TICK)) i_dut (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .lnk_clk(lnk_clk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
        .cmd_busy(cmd_busy), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_ok(rsp_ok), .aux_monitor_input(aux_in),
        .aux_monitor_sample(aux_smp), .ov_above_limit(ov_above_limit),
        .ov_below_recover(ov_below_recover), .write_protect(write_protect),
        .commanded_off(stop[0]), .bias_lost(stop[1]),
        .other_fault_off(stop[2]), .output_enable(output_enable),
        .ov_fault_status(ov_fault_status), .retry_pending(retry_pending),
        .fault_alert_line_o(alert_o), .fault_alert_line_oe(alert_oe));
    vmo_host_model i_host (.lnk_clk(lnk_clk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
        .cmd_busy(cmd_busy), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_ok(rsp_ok));
    always #12.5 clk_sys = ~clk_sys;
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // read data is only meaningful on an accepted read
    task automatic cmd(input logic [7:0] c, input logic w,
            input logic [15:0] d, input logic [15:0] er, input logic eo);
        i_host.xfer(c, w, d, rd, ok);
        chk({15'h0, ok}, {15'h0, eo});
        if (!w && eo) chk(rd, er);
    endtask
    // trip once, raise recover after rec cycles, time the output return
    task automatic trip(input logic [7:0] cfg, input int rec, input int lo,
            input int hi, input logic st);
        int n;
        n = 0;
        cmd(VMO_CMD_RESPONSE, 1'b1, {8'h00, cfg}, 16'h0, 1'b1);
        cmd(VMO_CMD_RESPONSE, 1'b0, 16'h0, {8'h00, cfg}, 1'b1);
        cmd(VMO_CMD_CLEAR_FAULTS, 1'b1, 16'h0000, 16'h0, 1'b1);
        @(posedge clk_sys);
        ov_below_recover <= 1'b0;
        ov_above_limit <= 1'b1;
        @(posedge clk_sys);
        ov_above_limit <= 1'b0;
        while (n < 400) begin
            @(posedge clk_sys);
            if (n == rec) ov_below_recover <= 1'b1;
            #1;
            n++;
            if (output_enable === 1'b1) break;
        end
        chk({15'h0, (n >= lo && n <= hi)}, 16'h0001);
        chk({15'h0, ov_fault_status}, {15'h0, st});
        chk({15'h0, alert_oe}, {15'h0, st});
    endtask
    initial begin
        // 5 clk_sys cycles, stretched so the link side sees reset too
        fork
            repeat (5) @(posedge clk_sys);
            i_host.run(6);
        join
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        cmd(VMO_CMD_RESPONSE, 1'b0, 16'h0, 16'h00BF, 1'b1);
        @(posedge clk_sys);
        aux_in <= 16'hD3A5;
        aux_smp <= 1'b1;
        @(posedge clk_sys);
        aux_in <= 16'h2C5A;
        aux_smp <= 1'b0;
        cmd(VMO_CMD_READING, 1'b0, 16'h0, 16'hD3A5, 1'b1);
        cmd(VMO_CMD_READING, 1'b1, 16'h1234, 16'h0, 1'b0);
        cmd(VMO_CMD_READING, 1'b0, 16'h0, 16'hD3A5, 1'b1);
        @(posedge clk_sys);
        write_protect <= 1'b1;
        cmd(VMO_CMD_RESPONSE, 1'b1, 16'h0000, 16'h0, 1'b0);
        cmd(VMO_CMD_RESPONSE, 1'b0, 16'h0, 16'h00BF, 1'b1);
        cmd(8'h5A, 1'b0, 16'h0, 16'h0, 1'b0);
        cmd(VMO_CMD_CLEAR_FAULTS, 1'b0, 16'h0, 16'h0, 1'b0);
        @(posedge clk_sys);
        write_protect <= 1'b0;
        trip(8'h00, 0, 1, 1, 1'b0);
        trip(8'h40, 0, 1, 1, 1'b0);
        trip(8'hBF, 0, 8 * TICK - 4, 8 * TICK + 6, 1'b1);
        trip(8'hB8, 0, TICK - 3, TICK + 6, 1'b1);
        trip(8'hBF, 200, 199, 206, 1'b1);
        trip(8'hC0, 30, 29, 35, 1'b1);
        trip(8'h88, 0, 400, 400, 1'b1);
        trip(8'h80, 0, 400, 400, 1'b1);
        cmd(VMO_CMD_CLEAR_FAULTS, 1'b1, 16'h0000, 16'h0, 1'b1);
        chk({15'h0, ov_fault_status}, 16'h0000);
        chk({15'h0, output_enable}, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_sys);
            stop <= 3'(1 << i);
            repeat (3) @(posedge clk_sys);
            #1;
            chk({15'h0, output_enable}, 16'h0000);
            @(posedge clk_sys);
            stop <= 3'h0;
            repeat (3) @(posedge clk_sys);
            #1;
            chk({15'h0, output_enable}, 16'h0001);
        end
        summarize();
    end
    initial begin
        #200000;
        failures++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
